// >>> usbcmd_dev.sv
// device end: command decoder, stall, setup interlock, resume, frame number
`timescale 1ns/100ps

// Contract
// (RQ1) 40h-45h status write; zero reinitialises endpoint
// (RQ2) stall bit set holds endpoint stalled
// (RQ3) setup token unstalls stalled control endpoint
// (RQ4) microcontroller may re-stall after setup
// (RQ5) leaving stall reinitialises and flushes buffer
// (RQ6) reinitialised out endpoint expects data0
// (RQ7) reinitialised in endpoint sends data0
// (RQ8) setup flushes control in buffer
// (RQ9) setup disables validate and clear commands
// (RQ10) f1h acknowledge re-enables validate and clear
// (RQ11) setup kept, nothing sent until acknowledged
// (RQ12) acknowledge issued for control in and out
// (RQ13) f6h drives upstream resume for 10 ms
// (RQ14) resume command has no data phase
// (RQ15) resume normally issued only while suspended
// (RQ16) f5h returns last good sof frame number
// (RQ17) frame read low byte then high byte
// (RQ18) 00h-05h select resets buffer pointer
// (RQ19) f2h clears out buffer full flag
// (RQ20) fah sets in buffer full flag
// (RQ21) command write then data bytes till next
module usbcmd_dev #(
  parameter int unsigned RESUME_CYC = usbcmd_pkg::RESUME_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // microcontroller port
  usbcmd_if.dev bus,
  // usb engine events
  input wire logic setup_rx_i,
  input wire logic [usbcmd_pkg::NUM_EP-1:0] pkt_ok_i,
  input wire logic sof_ok_i,
  input wire logic [usbcmd_pkg::FRAME_W-1:0] sof_frame_i,
  // endpoint state towards the usb engine
  output logic [usbcmd_pkg::NUM_EP-1:0] stall_o,
  output logic [usbcmd_pkg::NUM_EP-1:0] buf_full_o,
  output logic [usbcmd_pkg::NUM_EP-1:0] data_pid_o,
  output logic [usbcmd_pkg::NUM_EP-1:0] reinit_o,
  output logic [usbcmd_pkg::NUM_CTRL-1:0] ack_pend_o,
  output logic [usbcmd_pkg::EP_W-1:0] sel_ep_o,
  output logic ptr_rst_o,
  output logic resume_o
);
  import usbcmd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SELECT,
    ST_STATUS,
    ST_FRAME_LO,
    ST_FRAME_HI
  } usbcmd_state_t;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // true when a code falls in the per-endpoint range above base
  function automatic logic in_ep_range(input logic [7:0] code,
                                       input logic [7:0] base);
    in_ep_range = (code >= base) &&
                  (code < base + 8'(NUM_EP));
  endfunction

  usbcmd_state_t state;
  logic [EP_W-1:0] tgt_ep;
  logic [FRAME_W-1:0] frame;
  logic [FRAME_W-1:0] frame_snap;
  logic [31:0] resume_cnt;
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic status_wr;
  logic sel_cmd;
  logic status_cmd;
  logic sel_is_ctrl;
  logic cmd_lock;
  logic ack_cmd;
  logic clear_cmd;
  logic validate_cmd;
  logic [NUM_EP-1:0] reinit_now;

  // a0 high marks the command phase, low the data phase
  assign cmd_wr = bus.wr && bus.a0; // RQ21
  assign data_wr = bus.wr && !bus.a0;
  assign data_rd = bus.rd && !bus.a0;
  assign sel_cmd = cmd_wr && in_ep_range(bus.wdata, CMD_SEL_BASE);
  assign status_cmd = cmd_wr && in_ep_range(bus.wdata, CMD_STATUS_BASE);
  assign status_wr = data_wr && (state == ST_STATUS); // RQ1
  assign sel_is_ctrl = (sel_ep_o == CTRL_OUT_EP) ||
                       (sel_ep_o == CTRL_IN_EP);
  // any outstanding acknowledge locks both control endpoints
  assign cmd_lock = |ack_pend_o; // RQ9
  assign ack_cmd = cmd_wr && (bus.wdata == CMD_ACK_SETUP);
  assign clear_cmd = cmd_wr && (bus.wdata == CMD_CLEAR_BUF) &&
                     !(cmd_lock && sel_is_ctrl); // RQ9
  assign validate_cmd = cmd_wr && (bus.wdata == CMD_VALIDATE) &&
                        !(cmd_lock && sel_is_ctrl); // RQ9

  // endpoints leaving stall, or written zero, are reinitialised
  always_comb begin
    reinit_now = '0;
    for (int i = 0; i < NUM_EP; i++) begin
      if (status_wr && (tgt_ep == EP_W'(i)) &&
          !bus.wdata[STATUS_STALL_BIT]) begin
        reinit_now[i] = 1'b1; // RQ1 RQ5
      end
      if (setup_rx_i && (i < NUM_CTRL) && stall_o[i]) begin
        reinit_now[i] = 1'b1; // RQ3 RQ5
      end
    end
  end

  // ---------------------------------------------------------------
  // command phase tracking
  // ---------------------------------------------------------------
  // each command write restarts decoding of the data phase
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      tgt_ep <= '0;
    end else if (cmd_wr) begin
      tgt_ep <= bus.wdata[EP_W-1:0];
      if (sel_cmd) begin
        state <= ST_SELECT;
      end else if (status_cmd) begin
        state <= ST_STATUS;
      end else if (bus.wdata == CMD_FRAME) begin
        state <= ST_FRAME_LO; // RQ17
      end else begin
        state <= ST_IDLE; // RQ14
      end
    end else if (status_wr) begin
      state <= ST_IDLE;
    end else if (data_rd) begin
      unique case (state)
        ST_SELECT: state <= ST_IDLE;
        ST_FRAME_LO: state <= ST_FRAME_HI; // RQ17
        ST_FRAME_HI: state <= ST_IDLE;
        ST_IDLE: state <= ST_IDLE;
        ST_STATUS: state <= ST_STATUS;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // endpoint selection and buffer pointer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_ep_o <= CTRL_OUT_EP;
      ptr_rst_o <= 1'b0;
    end else begin
      ptr_rst_o <= sel_cmd; // RQ18
      if (sel_cmd) begin
        sel_ep_o <= bus.wdata[EP_W-1:0]; // RQ18
      end
    end
  end

  // ---------------------------------------------------------------
  // stall flags
  // ---------------------------------------------------------------
  // a setup in the same cycle as a re-stall write wins; software
  // re-stalls after it has seen the setup
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stall_o <= RST_STALL;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (setup_rx_i && (i < NUM_CTRL)) begin
          stall_o[i] <= 1'b0; // RQ3
        end else if (status_wr && (tgt_ep == EP_W'(i))) begin
          stall_o[i] <= bus.wdata[STATUS_STALL_BIT]; // RQ2 RQ4
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // buffer full flags
  // ---------------------------------------------------------------
  // even indices are out buffers, odd are in buffers; a set always
  // beats a clear so a packet arriving with a flush is kept
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buf_full_o <= RST_FULL;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if ((pkt_ok_i[i] && (i % 2 == 0)) ||
            (setup_rx_i && (i == CTRL_OUT_EP)) || // RQ11
            (validate_cmd && (sel_ep_o == EP_W'(i)) && (i % 2 == 1))) begin
          buf_full_o[i] <= 1'b1; // RQ20
        end else if (reinit_now[i] ||
                     (setup_rx_i && (i == CTRL_IN_EP)) ||
                     (pkt_ok_i[i] && (i % 2 == 1)) ||
                     (clear_cmd && (sel_ep_o == EP_W'(i)))) begin
          buf_full_o[i] <= 1'b0; // RQ5 RQ8 RQ19
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // data pid toggles and reinit pulse
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_pid_o <= RST_PID;
      reinit_o <= '0;
    end else begin
      reinit_o <= reinit_now; // RQ5
      for (int i = 0; i < NUM_EP; i++) begin
        if (reinit_now[i]) begin
          data_pid_o[i] <= 1'b0; // RQ6 RQ7
        end else if (pkt_ok_i[i]) begin
          data_pid_o[i] <= ~data_pid_o[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // setup acknowledge interlock
  // ---------------------------------------------------------------
  // one pending bit per control direction; the engine must send no
  // packet to the host while either bit stands
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_pend_o <= RST_ACK_PEND;
    end else begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        if (setup_rx_i) begin
          ack_pend_o[i] <= 1'b1; // RQ9 RQ11
        end else if (ack_cmd && (sel_ep_o == EP_W'(i))) begin
          ack_pend_o[i] <= 1'b0; // RQ10 RQ12
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // upstream resume timer
  // ---------------------------------------------------------------
  // a new resume command restarts the full period
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resume_cnt <= '0;
      resume_o <= 1'b0;
    end else if (cmd_wr && (bus.wdata == CMD_RESUME)) begin
      resume_cnt <= 32'(RESUME_CYC - 1); // RQ13
      resume_o <= 1'b1;
    end else if (resume_cnt != '0) begin
      resume_cnt <= resume_cnt - 32'h1;
    end else begin
      resume_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // frame number
  // ---------------------------------------------------------------
  // snapshot at the command so the two bytes always belong together
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame <= '0;
      frame_snap <= '0;
    end else begin
      if (sof_ok_i) begin
        frame <= sof_frame_i; // RQ16
      end
      if (cmd_wr && (bus.wdata == CMD_FRAME)) begin
        frame_snap <= frame; // RQ16
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // reads outside a readable data phase answer zero
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.rdata <= 8'h00;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= data_rd;
      if (data_rd) begin
        unique case (state)
          ST_SELECT: begin
            bus.rdata <= 8'h00;
            bus.rdata[SEL_FULL_BIT] <= buf_full_o[sel_ep_o];
            bus.rdata[SEL_STALL_BIT] <= stall_o[sel_ep_o];
          end
          ST_FRAME_LO: bus.rdata <= frame_snap[7:0]; // RQ17
          ST_FRAME_HI: bus.rdata <= 8'({frame_snap[FRAME_W-1:8]});
          ST_IDLE: bus.rdata <= 8'h00;
          ST_STATUS: bus.rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// >>> usbcmd_pkg.sv
// shared constants for the endpoint stall / setup / resume command block
package usbcmd_pkg;

  // ---------------------------------------------------------------
  // endpoint layout
  // ---------------------------------------------------------------
  localparam int unsigned NUM_EP = 6;
  localparam int unsigned EP_W = 3;
  localparam logic [EP_W-1:0] CTRL_OUT_EP = 3'h0;
  localparam logic [EP_W-1:0] CTRL_IN_EP = 3'h1;
  localparam int unsigned NUM_CTRL = 2;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_SEL_BASE = 8'h00;
  localparam logic [7:0] CMD_STATUS_BASE = 8'h40;
  localparam logic [7:0] CMD_ACK_SETUP = 8'hf1;
  localparam logic [7:0] CMD_CLEAR_BUF = 8'hf2;
  localparam logic [7:0] CMD_FRAME = 8'hf5;
  localparam logic [7:0] CMD_RESUME = 8'hf6;
  localparam logic [7:0] CMD_VALIDATE = 8'hfa;

  // ---------------------------------------------------------------
  // data byte fields
  // ---------------------------------------------------------------
  localparam int unsigned STATUS_STALL_BIT = 0;
  localparam int unsigned SEL_FULL_BIT = 0;
  localparam int unsigned SEL_STALL_BIT = 1;
  localparam int unsigned FRAME_W = 11;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [NUM_EP-1:0] RST_STALL = 6'h00;
  localparam logic [NUM_EP-1:0] RST_FULL = 6'h00;
  localparam logic [NUM_EP-1:0] RST_PID = 6'h00;
  localparam logic [NUM_CTRL-1:0] RST_ACK_PEND = 2'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 200000;
  localparam int unsigned RESUME_TIME_MS = 10;
  localparam int unsigned RESUME_CYCLES = RESUME_TIME_MS * CLK_FREQ_KHZ;

endpackage

// >>> usbcmd_if.sv
// command/data port between the microcontroller and the usb device
`timescale 1ns/100ps
interface usbcmd_if;
  logic wr;
  logic rd;
  logic a0;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;

  // documented device end
  modport dev (
    input wr,
    input rd,
    input a0,
    input wdata,
    output rdata,
    output rvalid
  );

  // microcontroller end
  modport mcu (
    output wr,
    output rd,
    output a0,
    output wdata,
    input rdata,
    input rvalid
  );
endinterface

// >>> usbcmd_mcu.sv
// microcontroller end: runs one command with its data phase per request, an acknowledge as four commands
`timescale 1ns/100ps
module usbcmd_mcu (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // device port
  usbcmd_if.mcu bus,
  // user request
  input wire logic req_i,
  input wire logic [7:0] req_cmd_i,
  input wire logic req_wr_i,
  input wire logic [7:0] req_wdata_i,
  input wire logic [1:0] req_nrd_i,
  input wire logic suspended_i,
  // user answer
  output logic ready_o,
  output logic done_o,
  output logic refused_o,
  output logic [15:0] rsp_data_o
);
  import usbcmd_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE,
    H_CMD,
    H_WR,
    H_RD,
    H_WAIT
  } usbcmd_hstate_t;

  usbcmd_hstate_t state;
  logic [7:0] cmd;
  logic [7:0] wdat;
  logic do_wr;
  logic [1:0] nrd;
  logic [1:0] rd_cnt;
  logic ack_seq;
  logic [1:0] seq;
  logic no_data;
  logic [1:0] req_rd;

  // ---------------------------------------------------------------
  // request shaping
  // ---------------------------------------------------------------
  // commands without a data phase never get one
  assign no_data = (req_cmd_i == CMD_RESUME) ||
                   (req_cmd_i == CMD_ACK_SETUP) ||
                   (req_cmd_i == CMD_CLEAR_BUF) ||
                   (req_cmd_i == CMD_VALIDATE); // RQ14
  // frame number is always read at least once, at most twice
  assign req_rd = no_data ? 2'h0 :
                  ((req_cmd_i == CMD_FRAME) && (req_nrd_i == 2'h0)) ?
                  2'h1 : (req_nrd_i == 2'h3 ? 2'h2 : req_nrd_i); // RQ17

  // ---------------------------------------------------------------
  // bus sequencer
  // ---------------------------------------------------------------
  // acknowledge expands to select out, ack, select in, ack
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= H_IDLE;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.a0 <= 1'b0;
      bus.wdata <= 8'h00;
      cmd <= 8'h00;
      wdat <= 8'h00;
      do_wr <= 1'b0;
      nrd <= 2'h0;
      rd_cnt <= 2'h0;
      ack_seq <= 1'b0;
      seq <= 2'h0;
      ready_o <= 1'b0;
      done_o <= 1'b0;
      refused_o <= 1'b0;
      rsp_data_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      refused_o <= 1'b0;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      unique case (state)
        H_IDLE: begin
          ready_o <= 1'b1;
          if (req_i && ready_o) begin
            if ((req_cmd_i == CMD_RESUME) && !suspended_i) begin
              refused_o <= 1'b1; // RQ15
            end else begin
              ready_o <= 1'b0;
              cmd <= req_cmd_i;
              wdat <= req_wdata_i;
              do_wr <= req_wr_i && !no_data; // RQ14
              nrd <= req_rd;
              rd_cnt <= 2'h0;
              rsp_data_o <= 16'h0000;
              ack_seq <= (req_cmd_i == CMD_ACK_SETUP); // RQ12
              seq <= 2'h0;
              bus.wr <= 1'b1;
              bus.a0 <= 1'b1;
              bus.wdata <= (req_cmd_i == CMD_ACK_SETUP) ?
                           (CMD_SEL_BASE + 8'(CTRL_OUT_EP)) : req_cmd_i;
              state <= H_CMD;
            end
          end
        end
        H_CMD, H_WR: begin
          if ((state == H_CMD) && do_wr) begin
            bus.wr <= 1'b1;
            bus.a0 <= 1'b0;
            bus.wdata <= wdat;
            state <= H_WR;
          end else if (rd_cnt < nrd) begin
            bus.rd <= 1'b1;
            bus.a0 <= 1'b0;
            state <= H_RD;
          end else if (ack_seq && (seq != 2'h3)) begin
            seq <= seq + 2'h1;
            bus.wr <= 1'b1;
            bus.a0 <= 1'b1;
            bus.wdata <= seq[0] ? (CMD_SEL_BASE + 8'(CTRL_IN_EP)) :
                         CMD_ACK_SETUP; // RQ12
            state <= H_CMD;
          end else begin
            done_o <= 1'b1;
            state <= H_IDLE;
          end
        end
        H_RD: begin
          state <= H_WAIT;
        end
        H_WAIT: begin
          if (bus.rvalid) begin
            // low byte arrives first
            if (rd_cnt == 2'h0) begin
              rsp_data_o[7:0] <= bus.rdata; // RQ17
            end else begin
              rsp_data_o[15:8] <= bus.rdata;
            end
            rd_cnt <= rd_cnt + 2'h1;
            if (rd_cnt + 2'h1 < nrd) begin
              bus.rd <= 1'b1;
              state <= H_RD;
            end else begin
              done_o <= 1'b1;
              state <= H_IDLE;
            end
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

endmodule

// >>> usbcmd_assertions.sv
// concurrent checks on the microcontroller/device command port
`timescale 1ns/100ps
module usbcmd_assertions (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // port signals
  input wire logic wr,
  input wire logic rd,
  input wire logic a0,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  import usbcmd_pkg::*;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  // a resume command leaves the port quiet for the next two cycles
  sequence quiet_two;
    !(wr || rd) ##1 !(wr || rd);
  endsequence
  // frame readout: a data read straight away, answered next cycle
  sequence rd_then_valid;
    (rd && !a0) ##1 rvalid;
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  rd_answer_a: assert property (rd && !a0 |=> rvalid)
    else $error("read strobe not answered next cycle");
  rvalid_cause_a: assert property (rvalid |-> $past(rd && !a0))
    else $error("read valid without a data read");
  rvalid_pulse_a: assert property (rvalid |=> !rvalid)
    else $error("read valid longer than one cycle");
  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobe together");
  resume_quiet_a: assert property (
    wr && a0 && wdata == CMD_RESUME |=> quiet_two)
    else $error("data phase after resume command");
  ack_nodata_a: assert property (
    wr && a0 && wdata == CMD_ACK_SETUP |=> !(!a0 && (wr || rd)))
    else $error("data phase after setup acknowledge");
  frame_read_a: assert property (
    wr && a0 && wdata == CMD_FRAME |=> rd_then_valid)
    else $error("frame command not followed by a read");
  // read data only moves together with its valid pulse
  rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data changed without valid");
endmodule

// >>> testbench.sv
// self-checking bench joining device and microcontroller ends
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp %h seen %h", nm, exp, got); \
  end \
end
module testbench;
  import usbcmd_pkg::*;
  // short resume so the run stays brief
  localparam int unsigned RES_CYC = 20;
  logic core_clk_i;
  logic rstn_i;
  logic setup_rx_i;
  logic [NUM_EP-1:0] pkt_ok_i;
  logic sof_ok_i;
  logic [FRAME_W-1:0] sof_frame_i;
  logic [NUM_EP-1:0] stall_o;
  logic [NUM_EP-1:0] buf_full_o;
  logic [NUM_EP-1:0] data_pid_o;
  logic [NUM_EP-1:0] reinit_o;
  logic [NUM_CTRL-1:0] ack_pend_o;
  logic [EP_W-1:0] sel_ep_o;
  logic ptr_rst_o;
  logic resume_o;
  logic req_i;
  logic [7:0] req_cmd_i;
  logic req_wr_i;
  logic [7:0] req_wdata_i;
  logic [1:0] req_nrd_i;
  logic suspended_i;
  logic ready_o;
  logic done_o;
  logic refused_o;
  logic [15:0] rsp_data_o;
  logic ref_seen;
  int mismatches = 0;
  int num_checks = 0;
  int n;

  usbcmd_if bus ();
  usbcmd_dev #(.RESUME_CYC(RES_CYC)) u_usbcmd_dev (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus(bus),
    .setup_rx_i(setup_rx_i), .pkt_ok_i(pkt_ok_i), .sof_ok_i(sof_ok_i),
    .sof_frame_i(sof_frame_i), .stall_o(stall_o), .buf_full_o(buf_full_o),
    .data_pid_o(data_pid_o), .reinit_o(reinit_o), .ack_pend_o(ack_pend_o),
    .sel_ep_o(sel_ep_o), .ptr_rst_o(ptr_rst_o), .resume_o(resume_o));
  usbcmd_mcu u_usbcmd_mcu (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus(bus), .req_i(req_i),
    .req_cmd_i(req_cmd_i), .req_wr_i(req_wr_i), .req_wdata_i(req_wdata_i),
    .req_nrd_i(req_nrd_i), .suspended_i(suspended_i), .ready_o(ready_o),
    .done_o(done_o), .refused_o(refused_o), .rsp_data_o(rsp_data_o));
  usbcmd_assertions u_usbcmd_assertions (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .wr(bus.wr), .rd(bus.rd),
    .a0(bus.a0), .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));

  // ------------------------------------------------------------
  // clock, verdict and watchdog
  // ------------------------------------------------------------
  always #2.5 core_clk_i = ~core_clk_i;

  task results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // tests need well under 1000 cycles
  initial begin
    #20000;
    mismatches++;
    results();
  end

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  // one command with its data phase; holds the request until taken
  task automatic run(input logic [7:0] c, input logic w,
    input logic [7:0] d, input logic [1:0] r);
    int k;
    req_cmd_i <= c;
    req_wr_i <= w;
    req_wdata_i <= d;
    req_nrd_i <= r;
    req_i <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (ready_o !== 1'b1 && k < 40);
    // a request never taken is a hang, so it counts against the run
    if (ready_o !== 1'b1) mismatches++;
    req_i <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (done_o !== 1'b1 && refused_o !== 1'b1 && k < 40);
    if (done_o !== 1'b1 && refused_o !== 1'b1) mismatches++;
    ref_seen = (refused_o === 1'b1);
  endtask

  // one-cycle engine event; outputs are read at the edge that follows
  task automatic ev(input logic s, input logic [NUM_EP-1:0] p,
    input logic f, input logic [FRAME_W-1:0] fr);
    setup_rx_i <= s;
    pkt_ok_i <= p;
    sof_ok_i <= f;
    sof_frame_i <= fr;
    @(posedge core_clk_i);
    setup_rx_i <= 1'b0;
    pkt_ok_i <= 6'h00;
    sof_ok_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    rstn_i = 1'b0;
    setup_rx_i = 1'b0;
    pkt_ok_i = 6'h00;
    sof_ok_i = 1'b0;
    sof_frame_i = 11'h000;
    req_i = 1'b0;
    req_cmd_i = 8'h00;
    req_wr_i = 1'b0;
    req_wdata_i = 8'h00;
    req_nrd_i = 2'h0;
    suspended_i = 1'b0;
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    `CHK("stall_rst", RST_STALL, stall_o)
    `CHK("ack_rst", RST_ACK_PEND, ack_pend_o)
    // toggle pids, then zero status on an endpoint that is not stalled
    ev(1'b0, 6'h0c, 1'b0, 11'h000);
    `CHK("pid_toggled", 2'h3, data_pid_o[3:2])
    run(CMD_STATUS_BASE + 8'h03, 1'b1, 8'h00, 2'h0);
    `CHK("pid_in", 1'b0, data_pid_o[3])
    `CHK("reinit_unstalled", 1'b1, reinit_o[3])
    for (int i = 0; i < NUM_EP; i++) begin
      run(CMD_STATUS_BASE + 8'(i), 1'b1, 8'h01, 2'h0);
      `CHK("stall_set", 1'b1, stall_o[i])
    end
    `CHK("stall_all", 6'h3f, stall_o)
    // unstall an out endpoint that holds a packet
    run(CMD_STATUS_BASE + 8'h02, 1'b1, 8'h00, 2'h0);
    `CHK("unstall", 1'b0, stall_o[2])
    `CHK("flush", 1'b0, buf_full_o[2])
    `CHK("pid_out", 1'b0, data_pid_o[2])
    `CHK("reinit_out", 1'b1, reinit_o[2])
    // load the control in buffer, then a setup arrives
    run(CMD_SEL_BASE + 8'h01, 1'b0, 8'h00, 2'h0);
    `CHK("ptr_rst", 1'b1, ptr_rst_o)
    run(CMD_VALIDATE, 1'b0, 8'h00, 2'h0);
    `CHK("ptr_idle", 1'b0, ptr_rst_o)
    `CHK("validate", 1'b1, buf_full_o[1])
    ev(1'b1, 6'h00, 1'b0, 11'h000);
    `CHK("ack_pend", 2'h3, ack_pend_o)
    `CHK("setup_unstall", 2'h0, stall_o[1:0])
    `CHK("setup_reinit", 2'h3, reinit_o[1:0])
    `CHK("setup_bufs", 2'h1, buf_full_o[1:0])
    run(CMD_STATUS_BASE, 1'b1, 8'h01, 2'h0);
    `CHK("restall", 1'b1, stall_o[0])
    // locked: validate and clear must be ignored
    run(CMD_SEL_BASE + 8'h01, 1'b0, 8'h00, 2'h0);
    run(CMD_VALIDATE, 1'b0, 8'h00, 2'h0);
    `CHK("val_locked", 1'b0, buf_full_o[1])
    run(CMD_SEL_BASE, 1'b0, 8'h00, 2'h0);
    run(CMD_CLEAR_BUF, 1'b0, 8'h00, 2'h0);
    `CHK("clr_locked", 1'b1, buf_full_o[0])
    run(CMD_ACK_SETUP, 1'b0, 8'h00, 2'h0);
    `CHK("ack_done", 2'h0, ack_pend_o)
    run(CMD_SEL_BASE, 1'b0, 8'h00, 2'h0);
    run(CMD_CLEAR_BUF, 1'b0, 8'h00, 2'h0);
    `CHK("clr_open", 1'b0, buf_full_o[0])
    `CHK("clr_open_ack", 2'h0, ack_pend_o)
    run(CMD_SEL_BASE + 8'h05, 1'b0, 8'h00, 2'h1);
    `CHK("sel_read", 8'h02, rsp_data_o[7:0])
    `CHK("sel_ep", 3'h5, sel_ep_o)
    // frame number, two reads then one
    ev(1'b0, 6'h00, 1'b1, 11'h5a3);
    run(CMD_FRAME, 1'b0, 8'h00, 2'h2);
    `CHK("frame2", 16'h05a3, rsp_data_o)
    ev(1'b0, 6'h00, 1'b1, 11'h7ff);
    run(CMD_FRAME, 1'b0, 8'h00, 2'h1);
    `CHK("frame1", 16'h00ff, rsp_data_o)
    // resume: refused while awake, timed while suspended
    run(CMD_RESUME, 1'b1, 8'h55, 2'h0);
    `CHK("res_refused", 1'b1, ref_seen)
    `CHK("res_idle", 1'b0, resume_o)
    suspended_i <= 1'b1;
    run(CMD_RESUME, 1'b0, 8'h00, 2'h0);
    n = 0;
    while (resume_o === 1'b1 && n < 100) begin
      n++;
      @(posedge core_clk_i);
    end
    `CHK("res_len", RES_CYC, n)
    results();
  end
endmodule
